// file: rtl/cal_pkg.sv
// Constants and types shared by the code-correction path.
// Assumes a 50 MHz system clock and a serial link clock from the host.
package cal_pkg;
	localparam int NUM_CH = 4;
	localparam int CODE_W = 16;
	localparam int GAIN_W = 8;
	localparam int ZERO_W = 9;
	localparam int FRAME_BITS = 24;
	localparam int ADDR_W = 4;
	// Register selectors carried in the frame address field
	localparam logic [3:0] SEL_CMD = 4'h0;
	localparam logic [3:0] SEL_CODE0 = 4'h4;
	localparam logic [3:0] SEL_ZERO0 = 4'h8;
	localparam logic [3:0] SEL_GAIN0 = 4'hc;
	localparam logic [3:0] SEL_READ = 4'h1;
	// Values after reset
	localparam logic [15:0] RESET_CODE = 16'h0000;
	localparam logic [7:0] RESET_GAIN = 8'h00;
	localparam logic [8:0] RESET_ZERO = 9'h000;
	localparam logic [3:0] RESET_GAIN_SEL = 4'hf;
	// Command register field positions
	localparam int CMD_GAIN_SEL_LSB = 0;
	localparam int CMD_SW_RESET_BIT = 8;
	typedef enum logic [1:0] {
		CALC_IDLE = 2'b00,
		CALC_RUN = 2'b01,
		CALC_DONE = 2'b11
	} calc_state_t;
endpackage

// file: rtl/code_cal.sv
// Four-channel code correction with per-channel gain and zero trim.
// Assumes a host on the serial link; polarity pins are asynchronous straps.
// Assumes a read-back word stays still for a few link cycles before it leaves.
// Function
// - Channels 0,1 are group A; channels 2,3 are group B.
// - Each channel has its own gain and zero trim correcting its output.
// - Gain and zero trims are signed two's complement.
// - Trims reset to zero, applying no correction.
// - One gain step moves full scale by one LSB unipolar, a quarter LSB bipolar.
// - One zero step shifts output by one eighth LSB.
// - Result is input code plus zero trim over eight.
// - Multiply by 1+gain/65536 unipolar, 1+gain/131072 bipolar.
// - Bipolar input codes are two's complement, -32768 to 32767.
// - Unipolar input codes are straight binary, 0 to 65535.
// - Gain trim limited to -128 through +127.
// - Zero trim limited to -256 through +255.
// - Read-back returns data in the format it was written.
// - Each channel gain factor is two or four by its gain-select bit.
// - Group polarity pin high means unipolar, low means bipolar.
// - Gain-select bits read one after any reset, selecting gain four.
`timescale 1ns/100ps
module code_cal (
	// System clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Serial link
	input wire logic link_clk,
	input wire logic cs_n,
	input wire logic sdi,
	output logic sdo,
	// Group polarity straps
	input wire logic polarity_select_group_a,
	input wire logic polarity_select_group_b,
	// Corrected codes to the converter channels
	output logic [15:0] dac_code0,
	output logic [15:0] dac_code1,
	output logic [15:0] dac_code2,
	output logic [15:0] dac_code3,
	output logic [3:0] gain_x4,
	output logic [1:0] unipolar
);
	// Frame from the link and its crossing
	logic [23:0] frame;
	logic frame_toggle;
	logic [2:0] tog_sync;
	logic [1:0] pa_sync;
	logic [1:0] pb_sync;
	// Register stores, one entry per channel, then soft reset and read-back state
	logic [15:0] code [0:3];
	logic [7:0] gain [0:3];
	logic [8:0] zero [0:3];
	logic [3:0] gain_sel;
	logic soft_reset;
	logic [3:0] read_sel;
	logic [15:0] read_word;
	logic [15:0] rw_sync0;
	logic [15:0] rw_sync1;
	logic [15:0] rw_held;
	// Shared calculator
	logic [1:0] ch;
	logic [15:0] math_out;
	logic [15:0] next_result;
	cal_pkg::calc_state_t state;
	logic [3:0] dirty;

	// Does a register selector fall into the four-entry block at base
	function automatic logic in_block(input logic [3:0] sel, input logic [3:0] base);
		in_block = (sel[3:2] == base[3:2]);
	endfunction

	// Group of a channel: bit 1 of the index picks group B
	function automatic logic ch_unipolar(input logic [1:0] c, input logic [1:0] mode);
		ch_unipolar = c[1] ? mode[1] : mode[0];
	endfunction

	// Link shifter runs entirely on the link clock
	link_shift u_link (
		.link_clk(link_clk),
		.rst_n(rst_n),
		.cs_n(cs_n),
		.sdi(sdi),
		.sdo(sdo),
		.frame(frame),
		.frame_toggle(frame_toggle),
		.read_word(rw_held)
	);

	// Frame toggle and straps cross into the system domain
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tog_sync <= 3'h0;
			pa_sync <= 2'h0;
			pb_sync <= 2'h0;
		end else begin
			tog_sync <= {tog_sync[1:0], frame_toggle};
			pa_sync <= {pa_sync[0], polarity_select_group_a};
			pb_sync <= {pb_sync[0], polarity_select_group_b};
		end
	end

	// Mode follows the pins: high is unipolar
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			unipolar <= 2'h0;
		end else begin
			unipolar <= {pb_sync[1], pa_sync[1]};
		end
	end

	wire frame_event = tog_sync[2] ^ tog_sync[1];
	wire [3:0] sel = frame[19:16];
	wire [15:0] data = frame[15:0];

	// Frame kind and target, decoded once per frame. The frame stays still for
	// many system clocks after the toggle, so reading it here is safe; each
	// strobe lasts a single cycle, so a frame lands exactly once
	wire wr_frame = frame_event && !frame[23];
	wire rd_frame = frame_event && frame[23];
	wire wr_cmd = wr_frame && (sel == cal_pkg::SEL_CMD);
	wire wr_code = wr_frame && in_block(sel, cal_pkg::SEL_CODE0);
	wire wr_zero = wr_frame && in_block(sel, cal_pkg::SEL_ZERO0);
	wire wr_gain = wr_frame && in_block(sel, cal_pkg::SEL_GAIN0);
	// Unmapped selectors match none of the strobes and are dropped

	// Input codes; a software reset clears them just as the pin does
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < cal_pkg::NUM_CH; i++) begin
				code[i] <= cal_pkg::RESET_CODE;
			end
		end else if (soft_reset) begin
			for (int i = 0; i < cal_pkg::NUM_CH; i++) begin
				code[i] <= cal_pkg::RESET_CODE;
			end
		end else if (wr_code) begin
			code[sel[1:0]] <= data;
		end
	end

	// Zero trims, nine bits signed; upper data bits are ignored
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < cal_pkg::NUM_CH; i++) begin
				zero[i] <= cal_pkg::RESET_ZERO;
			end
		end else if (soft_reset) begin
			for (int i = 0; i < cal_pkg::NUM_CH; i++) begin
				zero[i] <= cal_pkg::RESET_ZERO;
			end
		end else if (wr_zero) begin
			zero[sel[1:0]] <= data[8:0];
		end
	end

	// Gain trims, eight bits signed; upper data bits are ignored
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < cal_pkg::NUM_CH; i++) begin
				gain[i] <= cal_pkg::RESET_GAIN;
			end
		end else if (soft_reset) begin
			for (int i = 0; i < cal_pkg::NUM_CH; i++) begin
				gain[i] <= cal_pkg::RESET_GAIN;
			end
		end else if (wr_gain) begin
			gain[sel[1:0]] <= data[7:0];
		end
	end

	// Gain-select bits; every kind of reset brings them back to four
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gain_sel <= cal_pkg::RESET_GAIN_SEL;
		end else if (soft_reset) begin
			gain_sel <= cal_pkg::RESET_GAIN_SEL;
		end else if (wr_cmd) begin
			gain_sel <= data[cal_pkg::CMD_GAIN_SEL_LSB +: 4];
		end
	end

	// Software reset clears codes, trims and gain select like a hardware reset for one cycle, then clears itself
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			soft_reset <= 1'b0;
		end else if (soft_reset) begin
			soft_reset <= 1'b0;
		end else if (wr_cmd) begin
			soft_reset <= data[cal_pkg::CMD_SW_RESET_BIT];
		end
	end

	// Read selector from a read frame; the data leaves in the next frame
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			read_sel <= 4'h0;
		end else if (rd_frame) begin
			read_sel <= sel;
		end
	end

	// Read word, sign-extended so it comes back in the written format
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			read_word <= 16'h0000;
		end else if (read_sel == cal_pkg::SEL_CMD) begin
			read_word <= {12'h000, gain_sel};
		end else if (in_block(read_sel, cal_pkg::SEL_CODE0)) begin
			read_word <= code[read_sel[1:0]];
		end else if (in_block(read_sel, cal_pkg::SEL_ZERO0)) begin
			read_word <= {{7{zero[read_sel[1:0]][8]}}, zero[read_sel[1:0]]};
		end else if (in_block(read_sel, cal_pkg::SEL_GAIN0)) begin
			read_word <= {{8{gain[read_sel[1:0]][7]}}, gain[read_sel[1:0]]};
		end else begin
			read_word <= 16'h0000;
		end
	end

	// Read word toward the link: a word caught mid-change could mix old and new
	// bits, so the link side only takes it once two successive samples agree
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			rw_sync0 <= 16'h0000;
			rw_sync1 <= 16'h0000;
			rw_held <= 16'h0000;
		end else begin
			rw_sync0 <= read_word;
			rw_sync1 <= rw_sync0;
			if (rw_sync1 == rw_sync0) begin
				rw_held <= rw_sync1;
			end
		end
	end

	// One shared calculator; the mode comes from the group of the channel
	// being worked on, so both groups may run in different modes
	trim_math u_math (
		.code(code[ch]),
		.gain(gain[ch]),
		.zero(zero[ch]),
		.unipolar(ch_unipolar(ch, unipolar)),
		.result(math_out)
	);
	assign next_result = math_out;

	// A strap change moves both the format and the divisor of a group
	wire mode_change = (unipolar != {pb_sync[1], pa_sync[1]});

	// Channels needing a recompute: any write or mode change marks all
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dirty <= 4'hf;
		end else if (frame_event || soft_reset || mode_change) begin
			dirty <= 4'hf;
		end else if (state == cal_pkg::CALC_DONE) begin
			dirty[ch] <= 1'b0;
		end
	end

	// One shared calculator walks the channels in turn, saving three multipliers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= cal_pkg::CALC_IDLE;
			ch <= 2'h0;
		end else begin
			case (state)
				cal_pkg::CALC_IDLE: if (dirty != 4'h0) state <= cal_pkg::CALC_RUN;
				cal_pkg::CALC_RUN: state <= cal_pkg::CALC_DONE;
				cal_pkg::CALC_DONE: begin
					ch <= ch + 2'h1;
					state <= cal_pkg::CALC_IDLE;
				end
				default: state <= cal_pkg::CALC_IDLE;
			endcase
		end
	end

	// Corrected outputs, one channel latched per pass
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dac_code0 <= cal_pkg::RESET_CODE;
			dac_code1 <= cal_pkg::RESET_CODE;
			dac_code2 <= cal_pkg::RESET_CODE;
			dac_code3 <= cal_pkg::RESET_CODE;
		end else if (state == cal_pkg::CALC_DONE) begin
			case (ch)
				2'h0: dac_code0 <= next_result;
				2'h1: dac_code1 <= next_result;
				2'h2: dac_code2 <= next_result;
				default: dac_code3 <= next_result;
			endcase
		end
	end

	// Gain-select outputs, one per channel
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gain_x4 <= cal_pkg::RESET_GAIN_SEL;
		end else begin
			gain_x4 <= gain_sel;
		end
	end
endmodule

// file: rtl/link_shift.sv
// Serial receive and transmit shifter on the link clock.
// Assumes the host starts each frame with a falling edge after select low.
`timescale 1ns/100ps
module link_shift (
	// Link pins
	input wire logic link_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sdi,
	output logic sdo,
	// Frame results
	output logic [23:0] frame,
	output logic frame_toggle,
	input wire logic [15:0] read_word
);
	logic [4:0] count;
	logic [23:0] shreg;
	logic [15:0] tx;

	// Sample on falling edge; the first edge of a frame is falling by protocol
	// The pin reset clears the counter too, so the first frame is never lost
	always_ff @(negedge link_clk or posedge cs_n or negedge rst_n) begin
		if (!rst_n) begin
			count <= 5'h00;
			shreg <= 24'h000000;
		end else if (cs_n) begin
			count <= 5'h00;
			shreg <= 24'h000000;
		end else begin
			shreg <= {shreg[22:0], sdi};
			count <= count + 5'h01;
		end
	end

	// Complete frame captured; toggle tells the system domain
	always_ff @(negedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			frame <= 24'h000000;
			frame_toggle <= 1'b0;
		end else if (!cs_n && count == 5'(cal_pkg::FRAME_BITS - 1)) begin
			frame <= {shreg[22:0], sdi};
			frame_toggle <= ~frame_toggle;
		end
	end

	// Read word shifts out on rising edges, most significant bit first
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx <= 16'h0000;
		end else if (count == 5'd8) begin
			tx <= read_word;
		end else begin
			tx <= {tx[14:0], 1'b0};
		end
	end
	assign sdo = tx[15];
endmodule

// file: rtl/trim_math.sv
// Saturating trim arithmetic for one code.
// Combinational; the caller registers the result.
`timescale 1ns/100ps
module trim_math (
	// Operands
	input wire logic [15:0] code,
	input wire logic [7:0] gain,
	input wire logic [8:0] zero,
	input wire logic unipolar,
	// Result
	output logic [15:0] result
);
	logic signed [19:0] in8;
	logic signed [20:0] sum8;
	logic signed [38:0] prod;
	logic signed [38:0] scaled;

	// Work in eighths of a code so zero trim keeps its 1/8 step
	always_comb begin
		in8 = unipolar ? $signed({1'b0, code, 3'b000}) : $signed({code[15], code, 3'b000});
		sum8 = 21'(in8) + 21'($signed(zero));
		// Gain step is one LSB at unipolar full scale, a quarter LSB bipolar: scale by 65536 + g, or 131072 + g
		if (unipolar) begin
			prod = 39'(sum8) * 39'($signed({10'h000, 1'b1, 16'h0000}) + 39'($signed(gain)));
			scaled = prod >>> 19;
		end else begin
			prod = 39'(sum8) * 39'($signed({9'h000, 1'b1, 17'h00000}) + 39'($signed(gain)));
			scaled = prod >>> 20;
		end
		// Clamp to the mode range instead of wrapping
		if (unipolar) begin
			if (scaled < 0) result = 16'h0000;
			else if (scaled > 39'sd65535) result = 16'hffff;
			else result = scaled[15:0];
		end else begin
			if (scaled < -39'sd32768) result = 16'h8000;
			else if (scaled > 39'sd32767) result = 16'h7fff;
			else result = scaled[15:0];
		end
	end
endmodule

// file: testbench/code_cal_checker.sv
// Checker for code_cal: reset values, strap following, quiet gain select.
// Assumes it is bound to code_cal and sees only its ports.
`timescale 1ns/100ps
module code_cal_checker (
	// Clocks, reset and link
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic link_clk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic sdo,
	// Straps and outputs
	input wire logic polarity_select_group_a,
	input wire logic polarity_select_group_b,
	input wire logic [15:0] dac_code0,
	input wire logic [15:0] dac_code1,
	input wire logic [15:0] dac_code2,
	input wire logic [15:0] dac_code3,
	input wire logic [3:0] gain_x4,
	input wire logic [1:0] unipolar
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Straps pass three flops, so the mode may lag the pin by a few cycles
	property p_a_uni; polarity_select_group_a [*4] |-> unipolar[0]; endproperty
	a_a_uni: assert property (p_a_uni) else $error("group A mode lags strap");
	property p_b_bip; !polarity_select_group_b [*4] |-> !unipolar[1]; endproperty
	a_b_bip: assert property (p_b_bip) else $error("group B mode lags strap");
	// Each group's mode moves only with its own strap
	property p_a_own; $stable(polarity_select_group_a) [*5] |-> $stable(unipolar[0]); endproperty
	a_a_own: assert property (p_a_own) else $error("group A mode moved alone");
	property p_b_own; $stable(polarity_select_group_b) [*5] |-> $stable(unipolar[1]); endproperty
	a_b_own: assert property (p_b_own) else $error("group B mode moved alone");
	// Values at release of reset
	property p_gain_rst; $rose(rst_n) |-> (gain_x4 == 4'hf) [*4]; endproperty
	a_gain_rst: assert property (p_gain_rst) else $error("gain select not four");
	property p_code_rst;
		$rose(rst_n) |-> (dac_code0 | dac_code1 | dac_code2 | dac_code3) == 16'h0000;
	endproperty
	a_code_rst: assert property (p_code_rst) else $error("code not zero");
	property p_mode_rst; $rose(rst_n) |-> unipolar == 2'b00; endproperty
	a_mode_rst: assert property (p_mode_rst) else $error("mode not reset");
	// Gain select only moves as a frame completes, never on a quiet link
	property p_gain_quiet; cs_n [*8] |=> $stable(gain_x4); endproperty
	a_gain_quiet: assert property (p_gain_quiet) else $error("gain moved");
	c_frame: cover property ($rose(cs_n));
	c_gain: cover property ($changed(gain_x4));
	c_code: cover property ($changed(dac_code2));
	c_read: cover property (@(posedge link_clk) !cs_n && sdo);
	c_data: cover property (@(negedge link_clk) !cs_n && sdi);
endmodule
bind code_cal code_cal_checker chk (.sys_clk, .rst_n, .link_clk, .cs_n, .sdi, .sdo,
	.polarity_select_group_a, .polarity_select_group_b, .dac_code0, .dac_code1,
	.dac_code2, .dac_code3, .gain_x4, .unipolar);

// file: testbench/host_link.sv
// Host model of the serial link: 24-bit frames, MSB first, 160 ns clock.
// Assumes the bench calls one task at a time; the clock idles high.
`timescale 1ns/100ps
module host_link (
	// Link pins
	output logic link_clk,
	output logic cs_n,
	output logic sdi,
	input wire logic sdo
);
	initial begin
		link_clk = 1'b1;
		cs_n = 1'b1;
		sdi = 1'b0;
	end
	// Clock edges with select high, so link-side reset logic can release
	task automatic idle(input int n);
		repeat (n) begin
			#87 link_clk = 1'b0;
			#80 link_clk = 1'b1;
		end
	endtask
	// One frame; the odd offset keeps the link out of phase with the system clock
	task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
		rx = 24'h000000;
		#7 cs_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdi = tx[i];
			#80 link_clk = 1'b0;
			rx = {rx[22:0], sdo};
			#80 link_clk = 1'b1;
		end
		#40 cs_n = 1'b1;
		sdi = ~sdi; // Released line shows no stale value
		#400;
	endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench for code_cal: trims, modes, read-back and resets.
// Assumes host_link drives the link and the checker is bound in.
`timescale 1ns/100ps
module tb;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic pol_a = 1'b1;
	logic pol_b = 1'b0;
	logic link_clk, cs_n, sdi, sdo;
	logic [15:0] code0, code1, code2, code3;
	logic [3:0] gain_x4;
	logic [1:0] unipolar;
	int fail_count = 0;
	int num_checks = 0;
	always #10 sys_clk = ~sys_clk;
	code_cal DUT (.sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .cs_n(cs_n),
		.sdi(sdi), .sdo(sdo), .polarity_select_group_a(pol_a), .polarity_select_group_b(pol_b),
		.dac_code0(code0), .dac_code1(code1), .dac_code2(code2), .dac_code3(code3),
		.gain_x4(gain_x4), .unipolar(unipolar));
	host_link host (.link_clk(link_clk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
	// Compare and verdict
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Write a register, then wait out the recompute of all four slots
	task automatic wr(input logic [3:0] sel, input logic [15:0] data);
		logic [23:0] rx;
		host.xfer({4'h0, sel, data}, rx);
		repeat (40) @(negedge sys_clk);
	endtask
	// Read needs a second frame to carry the data out
	task automatic rd(input logic [3:0] sel, input logic [15:0] exp);
		logic [23:0] rx;
		host.xfer({4'h8, sel, 16'h0000}, rx);
		host.xfer({4'h8, sel, 16'h0000}, rx);
		check(rx[15:0], exp);
	endtask
	task automatic do_reset();
		@(negedge sys_clk);
		rst_n = 1'b0;
		repeat (4) @(negedge sys_clk);
		rst_n = 1'b1;
		host.idle(3);
		check({12'h000, gain_x4}, 16'h000f);
		check(code0 | code3, 16'h0000);
	endtask
	// Group A unipolar: offset step, gain step, saturation
	task automatic t_unipolar();
		check({14'h0000, unipolar}, 16'h0001);
		wr(cal_pkg::SEL_CODE0, 16'h8000);
		check(code0, 16'h8000);
		wr(cal_pkg::SEL_ZERO0, 16'h0008);
		check(code0, 16'h8001);
		wr(cal_pkg::SEL_ZERO0, 16'h0000);
		wr(cal_pkg::SEL_GAIN0, 16'h007f);
		check(code0, 16'h803f);
		wr(cal_pkg::SEL_CODE0, 16'hffff);
		check(code0, 16'hffff);
		check(code1, 16'h0000);
	endtask
	// Group B bipolar: negative floor, most negative gain, read-back
	task automatic t_bipolar();
		wr(cal_pkg::SEL_CODE0 + 4'h2, 16'h8000);
		wr(cal_pkg::SEL_ZERO0 + 4'h2, 16'h01f8);
		check(code2, 16'h8000);
		wr(cal_pkg::SEL_CODE0 + 4'h2, 16'h4000);
		wr(cal_pkg::SEL_ZERO0 + 4'h2, 16'h0000);
		wr(cal_pkg::SEL_GAIN0 + 4'h2, 16'h0080);
		check(code2, 16'h3ff0);
		rd(cal_pkg::SEL_GAIN0 + 4'h2, 16'hff80);
		wr(cal_pkg::SEL_ZERO0 + 4'h3, 16'h0100);
		rd(cal_pkg::SEL_ZERO0 + 4'h3, 16'hff00);
	endtask
	// Swap both straps; group B now uses the unipolar divisor
	task automatic t_mode();
		@(negedge sys_clk);
		pol_a = 1'b0;
		pol_b = 1'b1;
		repeat (40) @(negedge sys_clk);
		check({14'h0000, unipolar}, 16'h0002);
		check(code2, 16'h3fe0);
	endtask
	// Gain select bits, then soft reset restores gain select and clears codes
	task automatic t_cmd();
		wr(cal_pkg::SEL_CMD, 16'h0005);
		check({12'h000, gain_x4}, 16'h0005);
		wr(cal_pkg::SEL_CMD, 16'h0100);
		check({12'h000, gain_x4}, 16'h000f);
		check(code2, 16'h0000);
		wr(cal_pkg::SEL_CODE0, 16'h8000);
		check(code0, 16'h8000);
	endtask
	// Main sequence, ending with a second reset before the verdict
	initial begin
		do_reset();
		t_unipolar();
		t_bipolar();
		t_mode();
		t_cmd();
		do_reset();
		give_verdict();
	end
	// Watchdog
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		give_verdict();
	end
endmodule
